// ---- design/viu_top.sv ----
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "viu_defines.svh"

// Summary of operation
// - thirteen sources: one non-maskable, twelve maskable
// - watchdog mode 1 overflow: non-maskable, vector 0004H
// - watchdog overflow goes to exactly one path
// - interval-mode watchdog overflow: maskable priority 0
// - pin A priority 1 0006H, B 2 0008H
// - remote input rising edge: priority 3, 000AH
// - remote input falling edge: priority 4, 000CH
// - remote timer overflow: priority 5, 000EH
// - key scan event: priority 6, 0010H
// - serial transfer done: priority 7, 0012H
// - first timer match: priority 8, 0014H
// - second timer match: priority 9, 0016H
// - lowest number wins; watch 0018H, interval 001AH
// - serviced if flag set, unmasked, enabled
// - keep non-maskable servicing flag
// - pins select rising, falling or both edges
module viu_top
  import viu_pkg::*;
#(
  parameter int NSRC        = 12,
  parameter int STACK_DEPTH = 4
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_watchdog_overflow_irq,
  input  wire logic        i_ext_pin_a,
  input  wire logic        i_ext_pin_b,
  input  wire logic        i_remote_timer_input,
  input  wire logic        i_remote_overflow_irq,
  input  wire logic        i_key_scan_irq,
  input  wire logic        i_serial_done_irq,
  input  wire logic        i_timer_a_match_irq,
  input  wire logic        i_timer_b_match_irq,
  input  wire logic        i_watch_timer_irq,
  input  wire logic        i_watch_interval_irq,
  input  wire logic        i_cpu_ack,
  input  wire logic [15:0] i_cpu_pc,
  input  wire logic [7:0]  i_cpu_psw,
  input  wire logic        i_cpu_reti,
  output logic             o_int_req,
  output logic             o_int_nmi,
  output logic             o_take,
  output logic      [15:0] o_vector,
  output logic             o_ret_valid,
  output logic      [15:0] o_ret_pc,
  output logic      [7:0]  o_ret_psw,
  output logic             o_global_enable_flag,
  output logic             o_nonmask_servicing_flag,
  output logic             o_irq
);

  localparam int SELW = $clog2(NSRC);
  localparam int SPW  = $clog2(STACK_DEPTH + 1);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    viu_bus_st_t                   bus;
    logic                          waitreq;
    logic [31:0]                   rdata;
    logic                          glb_en;
    logic                          wd_nmi;
    logic [NSRC-1:0]               req_flag;
    logic [NSRC-1:0]               mask_flag;
    logic [3:0]                    edge_sel;
    logic [1:0]                    evt;
    logic [1:0]                    evmsk;
    logic                          irq;
    logic                          primed;
    logic                          prev_a;
    logic                          prev_b;
    logic                          prev_rin;
    logic                          nmi_pend;
    logic                          nmi_busy;
    logic                          int_req;
    logic                          is_nmi;
    logic [SELW-1:0]               sel;
    logic [15:0]                   vector;
    logic                          take;
    logic [STACK_DEPTH-1:0][23:0]  stk;
    logic [SPW-1:0]                sp;
    logic                          ret_valid;
    logic [15:0]                   ret_pc;
    logic [7:0]                    ret_psw;
  } viu_state_t;

  viu_state_t      s_ff;
  viu_state_t      nxt_s;
  logic            bus_hit;
  logic            bus_wr;
  logic [15:0]     wmask;
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] nxt_req;
  logic            ack_ok;
  logic            edge_a;
  logic            edge_b;
  logic            rin_rise;
  logic            rin_fall;

  // ----------------------------------------------------------------
  // source events
  // ----------------------------------------------------------------
  // edges are ignored on the first cycle after reset, because the
  // previous-level flops hold a constant rather than the real pin
  // pin edge choice
  assign edge_a   = s_ff.primed &
                    ((s_ff.edge_sel[`VIU_EDGE_RISE] &
                      i_ext_pin_a & ~s_ff.prev_a) |
                     (s_ff.edge_sel[`VIU_EDGE_FALL] &
                      ~i_ext_pin_a & s_ff.prev_a));
  assign edge_b   = s_ff.primed &
                    ((s_ff.edge_sel[2+`VIU_EDGE_RISE] &
                      i_ext_pin_b & ~s_ff.prev_b) |
                     (s_ff.edge_sel[2+`VIU_EDGE_FALL] &
                      ~i_ext_pin_b & s_ff.prev_b));
  assign rin_rise = s_ff.primed & i_remote_timer_input & ~s_ff.prev_rin;
  assign rin_fall = s_ff.primed & ~i_remote_timer_input & s_ff.prev_rin;

  // maskable sources in priority order, index equals priority
  // twelve maskable, watch interval last
  assign set_vec = NSRC'({i_watch_interval_irq, i_watch_timer_irq,
                          i_timer_b_match_irq, i_timer_a_match_irq,
                          i_serial_done_irq, i_key_scan_irq,
                          i_remote_overflow_irq, rin_fall, rin_rise,
                          edge_b, edge_a,
                          i_watchdog_overflow_irq & ~s_ff.wd_nmi});

  // ----------------------------------------------------------------
  // bus decode and request flag update
  // ----------------------------------------------------------------
  assign bus_hit = (s_ff.bus == BUS_IDLE) & (i_avs_read | i_avs_write);
  // a write lands only at the edge where waitrequest is low
  assign bus_wr  = (s_ff.bus == BUS_ACK) & i_avs_write;
  assign wmask   = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign ack_ok  = i_cpu_ack & s_ff.int_req;

  // grant and write-one clear both lose against a fresh event
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_flag
      assign clr_vec[g] = (bus_wr & (i_avs_address == `VIU_OFS_REQ) &
                           i_avs_writedata[g] & wmask[g]) |
                          (ack_ok & ~s_ff.is_nmi &
                           (s_ff.sel == SELW'(g)));
      assign nxt_req[g] = set_vec[g] | (s_ff.req_flag[g] & ~clr_vec[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NSRC-1:0] elig;
    logic            nmi_ok;
    logic [SPW-1:0]  slot;
    elig   = '0;
    nmi_ok = 1'b0;
    slot   = '0;
    nxt_s  = s_ff;
    nxt_s.take      = 1'b0;
    nxt_s.ret_valid = 1'b0;
    nxt_s.primed    = 1'b1;
    nxt_s.prev_a    = i_ext_pin_a;
    nxt_s.prev_b    = i_ext_pin_b;
    nxt_s.prev_rin  = i_remote_timer_input;
    nxt_s.req_flag  = nxt_req;

    // one wait state per access, then the answer stands one cycle
    case (s_ff.bus)
      BUS_IDLE: begin
        if (bus_hit) begin
          nxt_s.bus = BUS_ACK;
          case (i_avs_address)
            `VIU_OFS_CTRL:  nxt_s.rdata = 32'({s_ff.wd_nmi, s_ff.glb_en});
            `VIU_OFS_REQ:   nxt_s.rdata = 32'(s_ff.req_flag);
            `VIU_OFS_MASK:  nxt_s.rdata = 32'(s_ff.mask_flag);
            `VIU_OFS_EDGE:  nxt_s.rdata = 32'(s_ff.edge_sel);
            `VIU_OFS_STAT:  nxt_s.rdata = 32'({s_ff.sel, s_ff.is_nmi,
                                               s_ff.int_req,
                                               s_ff.nmi_pend,
                                               s_ff.nmi_busy});
            `VIU_OFS_EVT:   nxt_s.rdata = 32'(s_ff.evt);
            `VIU_OFS_EVMSK: nxt_s.rdata = 32'(s_ff.evmsk);
            default:        nxt_s.rdata = 32'h0000_0000;
          endcase
        end
      end
      BUS_ACK: begin
        nxt_s.bus = BUS_IDLE;
      end
      default: begin
        nxt_s.bus = BUS_IDLE;
      end
    endcase
    nxt_s.waitreq = (nxt_s.bus != BUS_ACK);

    // register writes; unmapped offsets are ignored
    if (bus_wr) begin
      case (i_avs_address)
        `VIU_OFS_CTRL: begin
          if (i_avs_byteenable[0]) begin
            nxt_s.glb_en = i_avs_writedata[`VIU_CTRL_GEN];
            nxt_s.wd_nmi = i_avs_writedata[`VIU_CTRL_WDNMI];
          end
        end
        `VIU_OFS_MASK: begin
          nxt_s.mask_flag = (s_ff.mask_flag & ~wmask[NSRC-1:0]) |
                            (i_avs_writedata[NSRC-1:0] & wmask[NSRC-1:0]);
        end
        `VIU_OFS_EDGE: begin
          if (i_avs_byteenable[0]) begin
            nxt_s.edge_sel = i_avs_writedata[3:0];
          end
        end
        `VIU_OFS_EVT: begin
          if (i_avs_byteenable[0]) begin
            nxt_s.evt = s_ff.evt & ~i_avs_writedata[1:0];
          end
        end
        `VIU_OFS_EVMSK: begin
          if (i_avs_byteenable[0]) begin
            nxt_s.evmsk = i_avs_writedata[1:0];
          end
        end
        default: begin
          nxt_s.evmsk = s_ff.evmsk;
        end
      endcase
    end

    // grant: push context, drop global enable, hand out the vector
    // context save and vector
    if (ack_ok) begin
      nxt_s.glb_en = 1'b0;
      nxt_s.take   = 1'b1;
      if (s_ff.is_nmi) begin
        nxt_s.vector   = `VIU_VEC_NMI;
        nxt_s.nmi_busy = 1'b1;
        nxt_s.nmi_pend = 1'b0;
        nxt_s.evt[`VIU_EVT_NMI] = 1'b1;
      end else begin
        nxt_s.vector = `VIU_VEC_BASE + 16'({s_ff.sel, 1'b0});
        nxt_s.evt[`VIU_EVT_MASKED] = 1'b1;
      end
      // a full stack overwrites its top entry
      slot = (s_ff.sp == SPW'(STACK_DEPTH)) ? s_ff.sp - 1'b1 : s_ff.sp;
      nxt_s.stk[slot] = {s_ff.glb_en, i_cpu_psw[`VIU_PSW_GEN-1:0], i_cpu_pc};
      nxt_s.sp = slot + 1'b1;
    end else if (i_cpu_reti) begin
      slot = (s_ff.sp == '0) ? '0 : s_ff.sp - 1'b1;
      nxt_s.sp        = slot;
      nxt_s.nmi_busy  = 1'b0;
      nxt_s.ret_valid = 1'b1;
      nxt_s.ret_pc    = s_ff.stk[slot][15:0];
      nxt_s.ret_psw   = s_ff.stk[slot][23:16];
      nxt_s.glb_en    = s_ff.stk[slot][16+`VIU_PSW_GEN];
    end

    if (i_watchdog_overflow_irq & s_ff.wd_nmi) begin
      nxt_s.nmi_pend = 1'b1;
    end
    nxt_s.irq = |(nxt_s.evt & nxt_s.evmsk);

    // arbitration on the next state, so a granted source never
    // shows as still requesting in the cycle after its grant
    // flag, mask, enable
    elig = nxt_s.req_flag & ~nxt_s.mask_flag & {NSRC{nxt_s.glb_en}};
    nmi_ok = nxt_s.nmi_pend & ~nxt_s.nmi_busy;
    nxt_s.int_req = nmi_ok | (|elig);
    nxt_s.is_nmi  = nmi_ok;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (elig[k]) begin
        nxt_s.sel = SELW'(k);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_ff           <= '0;
      s_ff.waitreq   <= 1'b1;
      s_ff.mask_flag <= `VIU_RST_MASK;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state flops
  assign o_avs_readdata           = s_ff.rdata;
  assign o_avs_waitrequest        = s_ff.waitreq;
  assign o_int_req                = s_ff.int_req;
  assign o_int_nmi                = s_ff.is_nmi;
  assign o_take                   = s_ff.take;
  assign o_vector                 = s_ff.vector;
  assign o_ret_valid              = s_ff.ret_valid;
  assign o_ret_pc                 = s_ff.ret_pc;
  assign o_ret_psw                = s_ff.ret_psw;
  assign o_global_enable_flag     = s_ff.glb_en;
  assign o_nonmask_servicing_flag = s_ff.nmi_busy;
  assign o_irq                    = s_ff.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  AST_REQ_HAS_CAUSE: assert property (
    o_int_req && !o_int_nmi |-> o_global_enable_flag &&
      s_ff.req_flag[s_ff.sel] && !s_ff.mask_flag[s_ff.sel])
    else $error("maskable request without enabled source");

  AST_PRIO_LOWEST: assert property (
    o_int_req && !o_int_nmi |->
      ((s_ff.req_flag & ~s_ff.mask_flag &
        ((NSRC'(1) << s_ff.sel) - NSRC'(1))) == '0))
    else $error("higher priority source was passed over");

  AST_NMI_VECTOR: assert property (
    i_cpu_ack && o_int_req && o_int_nmi |=>
      o_take && o_vector == `VIU_VEC_NMI && o_nonmask_servicing_flag)
    else $error("non-maskable grant gave wrong vector");

  AST_GRANT_CLEARS: assert property (
    i_cpu_ack && o_int_req && !o_int_nmi && !set_vec[s_ff.sel] |=>
      o_take && !o_global_enable_flag &&
      !s_ff.req_flag[$past(s_ff.sel)] &&
      o_vector == `VIU_VEC_BASE + 16'({$past(s_ff.sel), 1'b0}))
    else $error("maskable grant did not clear and vector");

  AST_NMI_NO_NEST: assert property (
    o_nonmask_servicing_flag |-> !(o_int_req && o_int_nmi))
    else $error("non-maskable offered while servicing");

  AST_RETI_CLEARS: assert property (
    i_cpu_reti && !(i_cpu_ack && o_int_req) |=>
      !o_nonmask_servicing_flag && o_ret_valid)
    else $error("return did not clear servicing flag");

  AST_WDOG_NMI_PATH: assert property (
    i_watchdog_overflow_irq && s_ff.wd_nmi &&
      !s_ff.req_flag[`VIU_SRC_WDOG] |=>
      s_ff.nmi_pend && !s_ff.req_flag[`VIU_SRC_WDOG])
    else $error("mode 1 overflow reached the maskable path");

  AST_WDOG_MASKABLE: assert property (
    i_watchdog_overflow_irq && !s_ff.wd_nmi |=>
      s_ff.req_flag[`VIU_SRC_WDOG])
    else $error("interval overflow did not set priority 0");

  AST_PIN_A_RISE: assert property (
    s_ff.primed && s_ff.edge_sel[`VIU_EDGE_RISE] && $rose(i_ext_pin_a)
      |=> s_ff.req_flag[`VIU_SRC_PIN_A])
    else $error("rising edge on pin a not flagged");

  AST_REMOTE_EDGES: assert property (
    s_ff.primed && $fell(i_remote_timer_input) |=>
      s_ff.req_flag[`VIU_SRC_FALL] && !$past(rin_rise))
    else $error("remote falling edge not flagged");

  // interrupt output follows masked status
  AST_IRQ_LEVEL: assert property (
    ##1 o_irq == |(s_ff.evt & s_ff.evmsk))
    else $error("interrupt output disagrees with status");

endmodule

// ---- inc/viu_defines.svh ----
`ifndef VIU_DEFINES_SVH
`define VIU_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VIU_OFS_CTRL   5'h00
`define VIU_OFS_REQ    5'h04
`define VIU_OFS_MASK   5'h08
`define VIU_OFS_EDGE   5'h0C
`define VIU_OFS_STAT   5'h10
`define VIU_OFS_EVT    5'h14
`define VIU_OFS_EVMSK  5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VIU_CTRL_GEN   0
`define VIU_CTRL_WDNMI 1
`define VIU_EDGE_RISE  0
`define VIU_EDGE_FALL  1
`define VIU_EVT_MASKED 0
`define VIU_EVT_NMI    1
`define VIU_PSW_GEN    7
`define VIU_SRC_WDOG   0
`define VIU_SRC_PIN_A  1
`define VIU_SRC_PIN_B  2
`define VIU_SRC_RISE   3
`define VIU_SRC_FALL   4
`define VIU_SRC_ROVF   5

// ----------------------------------------------------------------
// reset values and vector table
// ----------------------------------------------------------------
`define VIU_RST_MASK   12'hFFF
`define VIU_VEC_BASE   16'h0004
`define VIU_VEC_NMI    16'h0004

`endif

// ---- inc/viu_pkg.sv ----
package viu_pkg;
  // register bus handshake states
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } viu_bus_st_t;
endpackage

// ---- tb/test_vectored_interrupt_unit.sv ----
`timescale 1ns/1ns
`include "viu_defines.svh"
module test_vectored_interrupt_unit
  import viu_pkg::*;
;
  logic        clock;
  logic        rst_n;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic [11:0] src;
  logic        pin_a;
  logic        pin_b;
  logic        rmt;
  logic        ack;
  logic [15:0] pc;
  logic [15:0] last_pc;
  logic [7:0]  psw;
  logic        reti;
  logic        slow;
  logic        int_req;
  logic        nmi;
  logic        tk;
  logic [15:0] vec;
  logic        ret_valid;
  logic [15:0] ret_pc;
  logic [7:0]  ret_psw;
  logic        gen;
  logic        nonmask_servicing_flag;
  logic        irq;
  logic [31:0] q;
  logic [15:0] p1;
  int          mismatches;
  int          checked;

  viu_top u_viu_top (
    .i_clock(clock), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_watchdog_overflow_irq(src[0]),
    .i_ext_pin_a(pin_a), .i_ext_pin_b(pin_b),
    .i_remote_timer_input(rmt), .i_remote_overflow_irq(src[5]),
    .i_key_scan_irq(src[6]), .i_serial_done_irq(src[7]),
    .i_timer_a_match_irq(src[8]), .i_timer_b_match_irq(src[9]),
    .i_watch_timer_irq(src[10]), .i_watch_interval_irq(src[11]),
    .i_cpu_ack(ack), .i_cpu_pc(pc), .i_cpu_psw(psw),
    .i_cpu_reti(reti), .o_int_req(int_req), .o_int_nmi(nmi),
    .o_take(tk), .o_vector(vec), .o_ret_valid(ret_valid),
    .o_ret_pc(ret_pc), .o_ret_psw(ret_psw),
    .o_global_enable_flag(gen), .o_nonmask_servicing_flag(nonmask_servicing_flag),
    .o_irq(irq)
  );

  viu_cpu_model u_viu_cpu_model (
    .i_clock(clock), .i_rst_n(rst_n), .i_int_req(int_req),
    .i_take(tk), .i_slow(slow), .o_ack(ack), .o_pc(pc),
    .o_psw(psw), .o_last_pc(last_pc)
  );

  always #5 clock = ~clock;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task end_sim;
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic fail_now;
    mismatches++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim;
  endtask

  // request held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) fail_now;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask

  // bounded watch for a grant; a missing expected grant ends the run
  task automatic take(input logic want, input logic [15:0] v);
    int n;
    n = 0;
    while (tk !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (want && tk !== 1'b1) fail_now;
    else if (want) chk(vec, v);
    else begin
      chk(tk, 1'b0);
      chk(int_req, 1'b0);
    end
  endtask

  task automatic pulse(input logic [11:0] m);
    @(posedge clock);
    src <= m;
    @(posedge clock);
    src <= 12'h000;
  endtask

  task automatic ret(input logic [15:0] p);
    @(posedge clock);
    reti <= 1'b1;
    @(posedge clock);
    reti <= 1'b0;
    #1;
    chk(ret_valid, 1'b1);
    chk(ret_pc, p);
    chk(ret_psw, 8'h85);
    chk(nonmask_servicing_flag, 1'b0);
    chk(gen, 1'b1);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    clock = 0; rst_n = 0; rd = 0; wr = 0; addr = 0; wdata = 0;
    be = 4'hF; src = 0; pin_a = 0; pin_b = 0; rmt = 0; reti = 0;
    slow = 0; mismatches = 0; checked = 0; p1 = 0; q = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    // reset contents and an unmapped offset
    rdc(`VIU_OFS_MASK, 32'h00000FFF);
    rdc(`VIU_OFS_CTRL, 32'h00000000);
    rdc(`VIU_OFS_REQ, 32'h00000000);
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    rdc(5'h1C, 32'h00000000);
    // pin a on rising edges only, pin b on falling edges only
    bus(1'b1, `VIU_OFS_EDGE, 32'h00000009);
    @(posedge clock);
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    rdc(`VIU_OFS_REQ, 32'h00000002);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    rdc(`VIU_OFS_REQ, 32'h00000006);
    bus(1'b1, `VIU_OFS_REQ, 32'h00000006);
    rdc(`VIU_OFS_REQ, 32'h00000000);
    // all twelve maskable sources, remote falling edge one cycle after the rest, then served in order
    bus(1'b1, `VIU_OFS_EDGE, 32'h00000005);
    @(posedge clock);
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    rmt   <= 1'b1;
    src   <= 12'hFE1;
    @(posedge clock);
    rmt <= 1'b0;
    src <= 12'h000;
    rdc(`VIU_OFS_REQ, 32'h00000FFF);
    bus(1'b1, `VIU_OFS_MASK, 32'h00000000);
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, `VIU_OFS_CTRL, 32'h00000001);
      take(1'b1, 16'h0004 + 16'(2 * i));
      chk(gen, 1'b0);
    end
    rdc(`VIU_OFS_REQ, 32'h00000000);
    // masking and global enable gate service; slow core
    slow <= 1'b1;
    bus(1'b1, `VIU_OFS_MASK, 32'h00000040);
    bus(1'b1, `VIU_OFS_CTRL, 32'h00000001);
    pulse(12'h040);
    take(1'b0, 16'h0000);
    rdc(`VIU_OFS_REQ, 32'h00000040);
    bus(1'b1, `VIU_OFS_MASK, 32'h00000000);
    take(1'b1, 16'h0010);
    pulse(12'h080);
    take(1'b0, 16'h0000);
    be <= 4'h2;
    bus(1'b1, `VIU_OFS_CTRL, 32'h00000001);
    take(1'b0, 16'h0000);
    be <= 4'hF;
    bus(1'b1, `VIU_OFS_CTRL, 32'h00000001);
    take(1'b1, 16'h0012);
    // watchdog as the non-maskable source
    slow <= 1'b0;
    bus(1'b1, `VIU_OFS_CTRL, 32'h00000003);
    pulse(12'h001);
    take(1'b1, 16'h0004);
    chk(nonmask_servicing_flag, 1'b1);
    p1 = last_pc;
    rdc(`VIU_OFS_REQ, 32'h00000000);
    pulse(12'h001);
    take(1'b0, 16'h0000);
    ret(p1);
    chk(nmi, 1'b1);
    take(1'b1, 16'h0004);
    ret(last_pc);
    // grant events, their mask and the level interrupt line
    rdc(`VIU_OFS_EVT, 32'h00000003);
    chk(irq, 1'b0);
    bus(1'b1, `VIU_OFS_EVMSK, 32'h00000002);
    #1;
    chk(irq, 1'b1);
    bus(1'b1, `VIU_OFS_EVT, 32'h00000002);
    rdc(`VIU_OFS_EVT, 32'h00000001);
    chk(irq, 1'b0);
    bus(1'b1, `VIU_OFS_EVMSK, 32'h00000001);
    #1;
    chk(irq, 1'b1);
    bus(1'b1, `VIU_OFS_EVT, 32'h00000001);
    #1;
    chk(irq, 1'b0);
    end_sim;
  end
endmodule

// ---- tb/viu_cpu_model.sv ----
`timescale 1ns/1ns
module viu_cpu_model
  import viu_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_int_req,
  input  wire logic        i_take,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic      [15:0] o_pc,
  output logic      [7:0]  o_psw,
  output logic      [15:0] o_last_pc
);
  logic [1:0] wait_ff;
  logic       busy_ff;

  // --------------------------------------------------------------
  // acknowledge engine
  // --------------------------------------------------------------
  // a slow core lets the offer stand three cycles before acking;
  // after an ack it stays quiet until the take pulse arrives
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_ack     <= 1'b0;
      o_pc      <= 16'h1000;
      o_psw     <= 8'h05;
      o_last_pc <= 16'h0000;
      wait_ff   <= 2'd0;
      busy_ff   <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      if (o_ack && i_int_req) begin
        busy_ff   <= 1'b1;
        o_last_pc <= o_pc;
        o_pc      <= o_pc + 16'h0100; // fresh context per grant
        wait_ff   <= 2'd0;
      end else if (i_take) begin
        busy_ff <= 1'b0;
      end else if (!busy_ff && i_int_req && !o_ack) begin
        if (wait_ff == (i_slow ? 2'd3 : 2'd0)) begin
          o_ack <= 1'b1;
        end else begin
          wait_ff <= wait_ff + 2'd1;
        end
      end
    end
  end
endmodule
